/* rips_input_select.sv */
// Remappable input pin select: eight peripheral inputs, each routed from
// one of the remappable pins by its own 4-bit selector register.
// Assumes pad inputs are asynchronous and that variant straps are static.
//
// Contract
// - Each peripheral input has its own 4-bit selector choosing a pin.
// - Routing is per peripheral; only its selector picks its pin.
// - Codes 0000 to 1101 other than 1010 each map to one fixed remappable pin.
// - Codes 1010, 1110, 1111 are reserved and connect nothing.
// - On 64-pin parts codes 1001, 1100, 1101 connect nothing.
// - On 64-pin USB parts code 1011 connects nothing.
// - Code 1000 connects nothing while that pin serves USB ID detect.
// - Remappable inputs reach no pin until software assigns one.
// - Fixed peripherals keep default pins when active and unconflicted.
// - An active remapped input owns its pin over other digital uses.
// - Analog use of a pin always beats remapped use.
// - Input and output mapping use separate register sets.
// - Only the fixed remappable pin subset enters the multiplexer.
// - Only digital peripherals are remappable.
// - I2C and analog modules stay off the multiplexer.
// - A safeguard blocks spurious mapping changes once established.
//
// Decided for this implementation: the address-and-strobe port and the address map.

`timescale 1ns/1ps
`default_nettype none

module rips_input_select (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire rips_pkg::rips_bus_req_t bus_req,
    output logic [31:0] rdata,
    input wire logic [15:0] remappable_pin_n,
    input wire logic [15:0] pin_analog_mode,
    input wire logic variant_64pin,
    input wire logic variant_usb,
    input wire logic usb_identification_detect,
    output logic external_interrupt_one_input,
    output logic timer_three_clock_input,
    output logic capture_one_input,
    output logic uart_three_clear_to_send,
    output logic uart_four_receive,
    output logic uart_five_receive,
    output logic spi_two_slave_select,
    output logic compare_fault_a_input,
    output logic [15:0] pin_digital_claim,
    output logic map_locked
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    rips_pkg::rips_state_t st;
    rips_pkg::rips_state_t next_st;

    // Code-to-pin table: index = selector code, value = pin slot on the
    // remappable bus. Slot order equals code order, so the table is flat.
    logic [15:0] code_ok;
    logic [rips_pkg::NUM_INPUTS-1:0] route_ok;
    logic [rips_pkg::NUM_INPUTS-1:0] routed;
    logic [rips_pkg::NUM_INPUTS-1:0][15:0] claim_one;

    // ------------------------------------------------------------------
    // Code availability for this variant
    // ------------------------------------------------------------------
    // Straps are levels that never change during operation
    always_comb begin
        code_ok = 16'hFFFF;
        code_ok[rips_pkg::CODE_RSVD_A] = 1'b0;
        code_ok[rips_pkg::CODE_RSVD_E] = 1'b0;
        code_ok[rips_pkg::CODE_RSVD_F] = 1'b0;
        if (variant_64pin) begin
            code_ok[rips_pkg::CODE_PIN64_9] = 1'b0;
            code_ok[rips_pkg::CODE_PIN64_C] = 1'b0;
            code_ok[rips_pkg::CODE_PIN64_D] = 1'b0;
            if (variant_usb) begin
                code_ok[rips_pkg::CODE_USB64_PIN] = 1'b0;
            end
        end
        if (variant_usb && usb_identification_detect) begin
            code_ok[rips_pkg::CODE_USB_ID_PIN] = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Per-input routing
    // ------------------------------------------------------------------
    // Each input looks only at its own selector, never at other inputs
    genvar gi;
    generate
        for (gi = 0; gi < rips_pkg::NUM_INPUTS; gi++) begin : g_route
            // Analog on the chosen pin wins; the input then sees idle.
            // Code 0 is a real pin, so an unwritten selector must not route.
            assign route_ok[gi] = st.assigned[gi] && code_ok[st.sel[gi]]
                && !pin_analog_mode[st.sel[gi]];
            // Fixed code to pin mapping, synchronised pads only
            assign routed[gi] = route_ok[gi] ? st.pin_s2[st.sel[gi]]
                : rips_pkg::IDLE_LEVELS[gi];
            assign claim_one[gi] = route_ok[gi] ? (16'h0001 << st.sel[gi])
                : 16'h0000;
        end
    endgenerate

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        logic wr_sel;
        logic [2:0] idx;
        logic [15:0] claim_all;
        wr_sel = 1'b0;
        idx = 3'd0;
        claim_all = 16'h0000;
        next_st = st;

        // Two-stage pad sync; first stage read only by the second
        next_st.pin_s1 = remappable_pin_n;
        next_st.pin_s2 = st.pin_s1;
        next_st.periph_in = routed;

        // Ownership: remapped input claims pin over plain digital I/O
        for (int i = 0; i < rips_pkg::NUM_INPUTS; i++) begin
            claim_all = claim_all | claim_one[i];
        end
        next_st.claim = claim_all & ~pin_analog_mode;

        // Selector writes, one word per input, offsets 0x00..0x1C
        // Input selectors only; output mapping lives in its own set
        if (bus_req.addr[7:5] == 3'b000 && bus_req.addr[1:0] == 2'b00) begin
            wr_sel = bus_req.wr;
            idx = bus_req.addr[4:2];
        end
        if (wr_sel && !st.lock) begin
            next_st.sel[idx] = bus_req.wdata[3:0];
            next_st.assigned[idx] = 1'b1;
        end

        // Lock: software may set it at will; clearing needs the key pair
        if (bus_req.wr && bus_req.addr == rips_pkg::OFF_LOCK_CTRL
                && bus_req.wdata[rips_pkg::LOCK_BIT]) begin
            next_st.lock = 1'b1;
        end
        if (bus_req.wr && bus_req.addr == rips_pkg::OFF_UNLOCK_KEY) begin
            if (st.key == rips_pkg::RIPS_KEY_ONE
                    && bus_req.wdata == rips_pkg::UNLOCK_KEY_2) begin
                next_st.lock = 1'b0;
                next_st.key = rips_pkg::RIPS_KEY_IDLE;
            end else if (bus_req.wdata == rips_pkg::UNLOCK_KEY_1) begin
                next_st.key = rips_pkg::RIPS_KEY_ONE;
            end else begin
                next_st.key = rips_pkg::RIPS_KEY_IDLE;
            end
        end else if (bus_req.wr || bus_req.rd) begin
            // Any other access between the keys breaks the sequence
            next_st.key = rips_pkg::RIPS_KEY_IDLE;
        end

        // Read data, valid the cycle after the strobe only
        next_st.rdata = 32'h0000_0000;
        if (bus_req.rd) begin
            unique case (bus_req.addr)
                rips_pkg::OFF_EXT_EXTERNAL_INTERRUPT_ONE_INPUT: next_st.rdata[3:0] = st.sel[0];
                rips_pkg::OFF_TIMER3_CLK: next_st.rdata[3:0] = st.sel[1];
                rips_pkg::OFF_CAPTURE1: next_st.rdata[3:0] = st.sel[2];
                rips_pkg::OFF_UART3_CTS: next_st.rdata[3:0] = st.sel[3];
                rips_pkg::OFF_UART4_RX: next_st.rdata[3:0] = st.sel[4];
                rips_pkg::OFF_UART5_RX: next_st.rdata[3:0] = st.sel[5];
                rips_pkg::OFF_SPI2_SS: next_st.rdata[3:0] = st.sel[6];
                rips_pkg::OFF_CMP_FAULT_A: next_st.rdata[3:0] = st.sel[7];
                rips_pkg::OFF_LOCK_CTRL: next_st.rdata[rips_pkg::LOCK_BIT] = st.lock;
                default: next_st.rdata = 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    // Reset clears the assigned flags, so no input owns a pin until a
    // selector write lands, even though the selector itself reads zero
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            st <= '0;
            st.sel <= {rips_pkg::NUM_INPUTS{rips_pkg::SEL_RESET}};
            st.periph_in <= rips_pkg::IDLE_LEVELS;
            st.lock <= rips_pkg::LOCK_RESET;
            st.key <= rips_pkg::RIPS_KEY_IDLE;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------
    // Outputs, straight from flip-flops
    // ------------------------------------------------------------------
    // Fixed pins, I2C and analog modules never appear here
    assign rdata = st.rdata;
    assign external_interrupt_one_input = st.periph_in[0];
    assign timer_three_clock_input = st.periph_in[1];
    assign capture_one_input = st.periph_in[2];
    assign uart_three_clear_to_send = st.periph_in[3];
    assign uart_four_receive = st.periph_in[4];
    assign uart_five_receive = st.periph_in[5];
    assign spi_two_slave_select = st.periph_in[6];
    assign compare_fault_a_input = st.periph_in[7];
    assign pin_digital_claim = st.claim;
    assign map_locked = st.lock;

endmodule

`default_nettype wire

/* rips_input_select_assertions.sv */
// Checker for rips_input_select, watching its ports only.
// Assumes one clock domain with the synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module rips_input_select_assertions (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire rips_pkg::rips_bus_req_t bus_req,
    input wire logic [31:0] rdata,
    input wire logic [15:0] pin_analog_mode,
    input wire logic external_interrupt_one_input,
    input wire logic timer_three_clock_input,
    input wire logic capture_one_input,
    input wire logic uart_three_clear_to_send,
    input wire logic uart_four_receive,
    input wire logic uart_five_receive,
    input wire logic spi_two_slave_select,
    input wire logic compare_fault_a_input,
    input wire logic [15:0] pin_digital_claim,
    input wire logic map_locked
);
    logic [7:0] routed;
    logic key_a;
    logic key_b;
    // Routed inputs in register order; key writes decoded once
    assign routed = {compare_fault_a_input, spi_two_slave_select, uart_five_receive,
        uart_four_receive, uart_three_clear_to_send, capture_one_input,
        timer_three_clock_input, external_interrupt_one_input};
    assign key_a = bus_req.wr && bus_req.addr == rips_pkg::OFF_UNLOCK_KEY
        && bus_req.wdata == rips_pkg::UNLOCK_KEY_1;
    assign key_b = bus_req.wr && bus_req.addr == rips_pkg::OFF_UNLOCK_KEY
        && bus_req.wdata == rips_pkg::UNLOCK_KEY_2;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);
    a_rdata_quiet: assert property (!$past(bus_req.rd) |-> rdata == 32'h0000_0000)
        else $error("read data outside a read slot");
    a_upper_zero: assert property (bus_req.rd && bus_req.addr < 8'h20
        |=> rdata[31:4] == 28'h000_0000) else $error("selector upper bits set");
    a_key_hidden: assert property (bus_req.rd && bus_req.addr == rips_pkg::OFF_UNLOCK_KEY
        |=> rdata == 32'h0000_0000) else $error("key register readable");
    a_lock_sets: assert property (bus_req.wr && bus_req.addr == rips_pkg::OFF_LOCK_CTRL
        && bus_req.wdata[0] |=> map_locked) else $error("lock not set");
    a_lock_holds: assert property (map_locked && !key_b |=> map_locked)
        else $error("lock dropped without key");
    a_unlock_pair: assert property (key_a ##1 key_b |=> !map_locked)
        else $error("key pair did not unlock");
    a_idle_free: assert property (pin_digital_claim == 16'h0000
        |-> routed == rips_pkg::IDLE_LEVELS) else $error("unrouted input not idle");
    a_analog_wins: assert property ($stable(pin_analog_mode)
        |-> (pin_analog_mode & pin_digital_claim) == 16'h0000) else $error("analog pin claimed");
    // Main scenarios reached
    c_lock: cover property ($rose(map_locked));
    c_unlock: cover property (key_a ##1 key_b ##1 !map_locked);
    c_claim: cover property (pin_digital_claim == 16'h0000 ##1 pin_digital_claim != 16'h0000);
endmodule
bind rips_input_select rips_input_select_assertions rips_input_select_assertions_i (
    .clk_sys, .rst_b, .bus_req, .rdata, .pin_analog_mode, .external_interrupt_one_input,
    .timer_three_clock_input, .capture_one_input, .uart_three_clear_to_send,
    .uart_four_receive, .uart_five_receive, .spi_two_slave_select,
    .compare_fault_a_input, .pin_digital_claim, .map_locked
);
`default_nettype wire

/* rips_input_select_test.sv */
// Bench for rips_input_select: routing, straps, analog, lock and bus.
// Assumes the pad model and the bound checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module rips_input_select_test;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic v64 = 1'b0, vusb = 1'b0, id = 1'b0, locked;
    rips_pkg::rips_bus_req_t bus_req = '0;
    logic [31:0] rdata;
    logic [15:0] pins = 16'h0000, ana = 16'h0000, pad, pad_ana, claim;
    logic [7:0] outs;
    int n_fail = 0, n_tests = 0;
    initial forever #2 clk_sys = ~clk_sys;
    rips_pad_model rips_pad_model_i (.clk_sys, .want_pins(pins), .want_analog(ana),
        .remappable_pin_n(pad), .pin_analog_mode(pad_ana));
    rips_input_select rips_input_select_i (.clk_sys, .rst_b, .bus_req, .rdata,
        .remappable_pin_n(pad), .pin_analog_mode(pad_ana), .variant_64pin(v64),
        .variant_usb(vusb), .usb_identification_detect(id),
        .external_interrupt_one_input(outs[0]), .timer_three_clock_input(outs[1]),
        .capture_one_input(outs[2]), .uart_three_clear_to_send(outs[3]),
        .uart_four_receive(outs[4]), .uart_five_receive(outs[5]),
        .spi_two_slave_select(outs[6]), .compare_fault_a_input(outs[7]),
        .pin_digital_claim(claim), .map_locked(locked));
    // One comparison, counted and reported at once
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // Bus cycles start just after an edge and end on one
    task automatic bw(input logic [7:0] a, input logic [31:0] wd);
        bus_req <= '{a, wd, 1'b1, 1'b0};
        @(posedge clk_sys);
        bus_req.wr <= 1'b0;
        @(posedge clk_sys);
    endtask
    // Strobe held across both words so no other access slips between
    task automatic keys(input logic [31:0] k0, input logic [31:0] k1);
        bus_req <= '{rips_pkg::OFF_UNLOCK_KEY, k0, 1'b1, 1'b0};
        @(posedge clk_sys);
        bus_req.wdata <= k1;
        @(posedge clk_sys);
        bus_req.wr <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic br(input logic [7:0] a, input logic [31:0] exp, input string what);
        bus_req <= '{a, 32'h0000_0000, 1'b0, 1'b1};
        @(posedge clk_sys);
        bus_req.rd <= 1'b0;
        #1;
        chk(rdata, exp, what);
        @(posedge clk_sys);
    endtask
    task automatic do_reset();
        rst_b <= 1'b0;
        repeat (10) @(posedge clk_sys);
        rst_b <= 1'b1;
        @(posedge clk_sys);
    endtask
    // Codes that reach a pin under the present straps
    function automatic bit ok(input int c);
        return c <= 13 && c != 10 && !(v64 && (c == 9 || c >= 12))
            && !(v64 && vusb && c == 11) && !(vusb && id && c == 8);
    endfunction
    task automatic t_reset();
        for (int i = 0; i < 8; i++) begin
            br(8'(4 * i), 32'h0000_0000, "sel reset");
        end
        chk(32'(locked), 32'h0000_0000, "lock reset");
        // Every pad high: an unwritten selector must still route nothing
        pins <= 16'hFFFF;
        repeat (5) @(posedge clk_sys);
        chk(32'(outs), 32'(rips_pkg::IDLE_LEVELS), "unassigned idle");
        chk(32'(claim), 32'h0000_0000, "unassigned claim");
        $display("t_reset done");
    endtask
    // Each code on each input, both pad levels, every strap mix
    task automatic t_route();
        logic [7:0] e;
        for (int v = 0; v < 8; v++) begin
            {v64, vusb, id} <= 3'(v);
            for (int i = 0; i < 8; i++) begin
                for (int c = 0; c < 16; c++) begin
                    bw(8'(4 * i), 32'(c));
                    br(8'(4 * i), 32'(c), "readback");
                    for (int p = 0; p < 2; p++) begin
                        pins <= p ? 16'(1 << c) : ~16'(1 << c);
                        repeat (5) @(posedge clk_sys);
                        e = rips_pkg::IDLE_LEVELS;
                        if (ok(c)) e[i] = p[0];
                        chk(32'(outs), 32'(e), "route");
                        chk(32'(claim), ok(c) ? 32'(1 << c) : 32'h0000_0000, "claim");
                    end
                end
                bw(8'(4 * i), 32'h0000_000E);
            end
        end
        $display("t_route done");
    endtask
    task automatic t_analog();
        bw(rips_pkg::OFF_UART4_RX, 32'h0000_0003);
        pins <= 16'h0000;
        ana <= 16'h0008;
        repeat (5) @(posedge clk_sys);
        chk(32'(outs), 32'h0000_00F8, "analog idle");
        chk(32'(claim), 32'h0000_0000, "analog claim");
        ana <= 16'h0000;
        repeat (5) @(posedge clk_sys);
        chk(32'(outs), 32'h0000_00E8, "digital route");
        chk(32'(claim), 32'h0000_0008, "digital claim");
        $display("t_analog done");
    endtask
    task automatic t_lock();
        bw(rips_pkg::OFF_LOCK_CTRL, 32'h0000_0001);
        chk(32'(locked), 32'h0000_0001, "lock set");
        bw(rips_pkg::OFF_UART4_RX, 32'h0000_0005);
        br(rips_pkg::OFF_UART4_RX, 32'h0000_0003, "locked write");
        bw(rips_pkg::OFF_LOCK_CTRL, 32'h0000_0000);
        keys(rips_pkg::UNLOCK_KEY_2, rips_pkg::UNLOCK_KEY_1);
        chk(32'(locked), 32'h0000_0001, "key order");
        keys(rips_pkg::UNLOCK_KEY_1, rips_pkg::UNLOCK_KEY_2);
        chk(32'(locked), 32'h0000_0000, "unlock");
        $display("t_lock done");
    endtask
    task automatic t_bus();
        br(8'h30, 32'h0000_0000, "unmapped");
        br(rips_pkg::OFF_UNLOCK_KEY, 32'h0000_0000, "key read");
        bw(rips_pkg::OFF_UART4_RX, 32'hFFFF_FFF5);
        bw(8'h11, 32'h0000_0007);
        br(rips_pkg::OFF_UART4_RX, 32'h0000_0005, "field only");
        bw(rips_pkg::OFF_LOCK_CTRL, 32'h0000_0001);
        $display("t_bus done");
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        do_reset();
        t_reset();
        for (int i = 0; i < 8; i++) begin
            bw(8'(4 * i), 32'h0000_000E);
        end
        t_route();
        t_analog();
        t_lock();
        t_bus();
        do_reset();
        t_reset();
        end_of_test();
    end
    // Hang guard
    initial begin
        #400000;
        n_fail++;
        $display("[ERR] %0t run timed out", $time);
        end_of_test();
    end
endmodule
`default_nettype wire

/* rips_pad_model.sv */
// Pad model: drives the remappable pad levels and the analog pin modes.
// Assumes the bench asks for levels; pads follow on the next rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module rips_pad_model (
    input wire logic clk_sys,
    input wire logic [15:0] want_pins,
    input wire logic [15:0] want_analog,
    output logic [15:0] remappable_pin_n,
    output logic [15:0] pin_analog_mode
);
    // Pads change on the rising edge by nonblocking update, so the design samples the old level cleanly
    always_ff @(posedge clk_sys) begin
        remappable_pin_n <= want_pins;
        pin_analog_mode <= want_analog;
    end
endmodule
`default_nettype wire

/* rips_pkg.sv */
// Package for the remappable input pin select block.
// Holds register offsets, field layout, selector codes and carrier structs.
// Assumes a plain address/strobe register port on the system clock.
package rips_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int NUM_INPUTS = 8;
    localparam int NUM_PINS = 16;
    localparam int SEL_W = 4;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // ------------------------------------------------------------------
    // Register offsets (byte addresses, one word each)
    // ------------------------------------------------------------------
    localparam logic [7:0] OFF_EXT_EXTERNAL_INTERRUPT_ONE_INPUT = 8'h00;
    localparam logic [7:0] OFF_TIMER3_CLK = 8'h04;
    localparam logic [7:0] OFF_CAPTURE1 = 8'h08;
    localparam logic [7:0] OFF_UART3_CTS = 8'h0C;
    localparam logic [7:0] OFF_UART4_RX = 8'h10;
    localparam logic [7:0] OFF_UART5_RX = 8'h14;
    localparam logic [7:0] OFF_SPI2_SS = 8'h18;
    localparam logic [7:0] OFF_CMP_FAULT_A = 8'h1C;
    localparam logic [7:0] OFF_LOCK_CTRL = 8'h20;
    localparam logic [7:0] OFF_UNLOCK_KEY = 8'h24;

    // ------------------------------------------------------------------
    // Field layout and reset values
    // ------------------------------------------------------------------
    localparam int SEL_LSB = 0;
    localparam int LOCK_BIT = 0;
    localparam logic [3:0] SEL_RESET = 4'h0;
    localparam logic LOCK_RESET = 1'b0;

    // Unlock sequence: two key words written back to back
    localparam logic [31:0] UNLOCK_KEY_1 = 32'hAA99_6655;
    localparam logic [31:0] UNLOCK_KEY_2 = 32'h5566_99AA;

    // ------------------------------------------------------------------
    // Selector codes with restrictions
    // ------------------------------------------------------------------
    localparam logic [3:0] CODE_USB_ID_PIN = 4'h8;
    localparam logic [3:0] CODE_RSVD_A = 4'hA;
    localparam logic [3:0] CODE_USB64_PIN = 4'hB;
    localparam logic [3:0] CODE_PIN64_C = 4'hC;
    localparam logic [3:0] CODE_PIN64_D = 4'hD;
    localparam logic [3:0] CODE_RSVD_E = 4'hE;
    localparam logic [3:0] CODE_RSVD_F = 4'hF;
    localparam logic [3:0] CODE_PIN64_9 = 4'h9;

    // Inactive level per routed input, bit order as the register order.
    // Interrupt, clock, capture high-idle is false; UART receive, clear
    // to send, slave select and fault idle high.
    localparam logic [7:0] IDLE_LEVELS = 8'b1111_1000;

    // ------------------------------------------------------------------
    // Carrier structs
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } rips_bus_req_t;

    typedef enum logic [1:0] {
        RIPS_KEY_IDLE = 2'b00,
        RIPS_KEY_ONE = 2'b01
    } rips_key_t;

    typedef struct packed {
        logic [NUM_INPUTS-1:0][SEL_W-1:0] sel;
        logic [NUM_INPUTS-1:0] assigned;
        logic lock;
        rips_key_t key;
        logic [31:0] rdata;
        logic [NUM_PINS-1:0] pin_s1;
        logic [NUM_PINS-1:0] pin_s2;
        logic [NUM_INPUTS-1:0] periph_in;
        logic [NUM_PINS-1:0] claim;
    } rips_state_t;

endpackage
